//--- logic/ascs_pkg.sv
package ascs_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CTRL_ONE_OFS   = 8'h00;
  localparam logic [7:0] CTRL_TWO_OFS   = 8'h04;
  localparam logic [7:0] CTRL_THREE_OFS = 8'h08;
  localparam logic [7:0] IRQ_FLAG_OFS   = 8'h0c;
  localparam logic [7:0] BUF_BASE_OFS   = 8'h40;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ON_POS       = 15;
  localparam int TRIG_LSB     = 5;
  localparam int STOP_POS     = 4;
  localparam int AUTO_POS     = 2;
  localparam int SAMPLE_POS   = 1;
  localparam int DONE_POS     = 0;
  localparam int OFFSET_CAL_ENABLE_POS   = 12;
  localparam int SPI_LSB      = 2;
  localparam int STC_LSB      = 0;
  localparam int TAD_DIV_LSB  = 8;
  localparam int IRQ_POS      = 1;
  // ************************************************************
  // values after reset and counts
  // ************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  DIV_RST  = 8'h00;
  localparam logic [3:0]  CONV_TADS = 4'hc;
  localparam logic [2:0]  TRIG_SW    = 3'h0;
  localparam logic [2:0]  TRIG_CLKD  = 3'h7;
  localparam int          BUF_WORDS  = 16;
  localparam int          RES_W      = 10;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } ascs_state_t;

  typedef struct packed {
    logic       on;
    logic [2:0] trig_src;
    logic       stop_after_seq;
    logic       auto_sample;
    logic       sample;
    logic       done;
  } ascs_ctl_t;
endpackage

//--- logic/ascs_top.sv
`timescale 1ns/1ns
// Functional notes
// - offset calibration bit forces both sample-and-hold inputs to analog ground
// - calibration conversions are stored into the result buffer like normal results
// - clearing calibration bit restores normal input selection
// - auto-clear: after one sequence hardware clears auto-sample and sets irq flag
// - hardware never clears the auto-clear bit itself
// - auto-clear works regardless of interrupt enable or mask
// - completion bit set when a conversion sequence finishes
// - manual mode: completion bit stays set until software clears it
// - auto mode: completion bit cleared when next acquisition starts
// - irq flag latched at sequence end, held until cleared
// - trigger 000: software clearing sample bit ends acquisition, starts conversion
// - auto-sample returns to acquisition after each conversion
// - auto acquisition sets the sample bit itself
// - trigger 111: count sample-time TAD periods then start conversion
// - auto-sample bit starts sampling, selected trigger starts conversion
// - a conversion takes twelve TAD periods
// - clearing module enable aborts conversion, buffer left unchanged
// - samples-per-interrupt plus one conversions per sequence
// - manual mode: clearing sample bit ends acquisition except under 111, converts only for 000
module ascs_top (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  input  wire logic [7:0]              addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    we,
  input  wire logic                    re,
  output logic [31:0]                  rdata,
  input  wire logic [ascs_pkg::RES_W-1:0] core_result,
  input  wire logic                    ext_trigger,
  output logic                         sh_to_ground,
  output logic                         sampling,
  output logic                         converting
);
  import ascs_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  ascs_ctl_t          ctl_r, ctl_nxt;
  logic               offset_cal_r, offset_cal_nxt;
  logic [3:0]         spi_r, spi_nxt;
  logic [4:0]         stc_r, stc_nxt;
  logic [7:0]         div_r, div_nxt;
  logic               irq_r, irq_nxt;
  ascs_state_t        state_r, state_nxt;
  logic [8:0]         tad_cnt_r, tad_cnt_nxt;
  logic [4:0]         sample_bit_cnt_r, sample_bit_cnt_nxt;
  logic [3:0]         conv_cnt_r, conv_cnt_nxt;
  logic [3:0]         seq_cnt_r, seq_cnt_nxt;
  logic [3:0]         ptr_r, ptr_nxt;
  logic [RES_W-1:0]   buf_r [BUF_WORDS];
  logic [31:0]        rdata_r, rdata_nxt;
  logic               sh_gnd_r, sampling_r, converting_r;
  logic [2:0]         sync_r;
  logic               trig_lvl_r, trig_lvl_nxt;
  logic               tad_tick, store, seq_end, trig_rise;
  logic               wr_one, wr_two, wr_three, wr_irq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_one   = we && hit(addr, CTRL_ONE_OFS);
  assign wr_two   = we && hit(addr, CTRL_TWO_OFS);
  assign wr_three = we && hit(addr, CTRL_THREE_OFS);
  assign wr_irq   = we && hit(addr, IRQ_FLAG_OFS);

  // ************************************************************
  // external trigger, three stages, accepted when last two agree
  // ************************************************************
  always_comb begin
    trig_lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : trig_lvl_r;
    trig_rise    = (sync_r[1] == sync_r[2]) && sync_r[2] && !trig_lvl_r;
  end

  // ************************************************************
  // tad divider, period 2*(div+1) core clocks
  // ************************************************************
  always_comb begin
    tad_tick    = (tad_cnt_r == {div_r, 1'b1});
    tad_cnt_nxt = (tad_tick || !ctl_r.on) ? 9'h000 : tad_cnt_r + 9'h001;
  end

  // ************************************************************
  // sequencer and registers
  // ************************************************************
  always_comb begin
    ctl_nxt        = ctl_r;
    offset_cal_nxt = offset_cal_r;
    spi_nxt        = spi_r;
    stc_nxt        = stc_r;
    div_nxt        = div_r;
    irq_nxt        = irq_r;
    state_nxt      = state_r;
    sample_bit_cnt_nxt   = sample_bit_cnt_r;
    conv_cnt_nxt   = conv_cnt_r;
    seq_cnt_nxt    = seq_cnt_r;
    ptr_nxt        = ptr_r;
    store          = 1'b0;
    seq_end        = 1'b0;
    if (wr_one) begin
      ctl_nxt.on             = wdata[ON_POS];
      ctl_nxt.trig_src       = wdata[TRIG_LSB +: 3];
      ctl_nxt.stop_after_seq = wdata[STOP_POS];
      ctl_nxt.auto_sample    = wdata[AUTO_POS];
      ctl_nxt.sample         = wdata[SAMPLE_POS];
      ctl_nxt.done           = wdata[DONE_POS];
    end
    if (wr_two) begin
      offset_cal_nxt = wdata[OFFSET_CAL_ENABLE_POS];
      spi_nxt        = wdata[SPI_LSB +: 4];
    end
    if (wr_three) begin
      stc_nxt = wdata[STC_LSB +: 5];
      div_nxt = wdata[TAD_DIV_LSB +: 8];
    end
    if (wr_irq) begin
      irq_nxt = wdata[IRQ_POS];
    end
    case (state_r)
      ST_IDLE: begin
        sample_bit_cnt_nxt = 5'h00;
        conv_cnt_nxt = 4'h0;
        if (ctl_r.on && ctl_r.auto_sample) begin
          ctl_nxt.sample = 1'b1;
          ctl_nxt.done   = 1'b0;
          state_nxt      = ST_SAMPLE;
        end else if (ctl_r.on && ctl_r.sample) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!ctl_r.on) begin
          state_nxt = ST_IDLE;
        end else if (ctl_r.trig_src == TRIG_CLKD) begin
          if (tad_tick) begin
            sample_bit_cnt_nxt = sample_bit_cnt_r + 5'h01;
          end
          // a zero count behaves as one tad; software must not rely on it
          if (tad_tick && (sample_bit_cnt_r + 5'h01 >= stc_r)) begin
            ctl_nxt.sample = 1'b0;
            state_nxt      = ST_CONVERT;
          end
        end else if (!ctl_r.sample) begin
          // trigger 000 converts; any other source just ends the acquisition
          state_nxt = (ctl_r.trig_src == TRIG_SW) ? ST_CONVERT : ST_IDLE;
        end else if (trig_rise) begin
          ctl_nxt.sample = 1'b0;
          state_nxt      = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!ctl_r.on) begin
          state_nxt = ST_IDLE;
        end else if (tad_tick) begin
          conv_cnt_nxt = conv_cnt_r + 4'h1;
          if (conv_cnt_r == CONV_TADS - 4'h1) begin
            store     = 1'b1;
            state_nxt = ST_IDLE;
            ptr_nxt   = ptr_r + 4'h1;
            seq_cnt_nxt = seq_cnt_r + 4'h1;
            if (seq_cnt_r == spi_r) begin
              seq_end     = 1'b1;
              seq_cnt_nxt = 4'h0;
              ptr_nxt     = 4'h0;
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (seq_end) begin
      // hardware set wins over a same-cycle software clear
      ctl_nxt.done = 1'b1;
      irq_nxt      = 1'b1;
      if (ctl_r.stop_after_seq) begin
        ctl_nxt.auto_sample = 1'b0;
      end
    end
  end

  // ************************************************************
  // read data, one cycle after the strobe
  // ************************************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (re) begin
      if (hit(addr, CTRL_ONE_OFS)) begin
        rdata_nxt[ON_POS]         = ctl_r.on;
        rdata_nxt[TRIG_LSB +: 3]  = ctl_r.trig_src;
        rdata_nxt[STOP_POS]       = ctl_r.stop_after_seq;
        rdata_nxt[AUTO_POS]       = ctl_r.auto_sample;
        rdata_nxt[SAMPLE_POS]     = ctl_r.sample;
        rdata_nxt[DONE_POS]       = ctl_r.done;
      end else if (hit(addr, CTRL_TWO_OFS)) begin
        rdata_nxt[OFFSET_CAL_ENABLE_POS]     = offset_cal_r;
        rdata_nxt[SPI_LSB +: 4]   = spi_r;
      end else if (hit(addr, CTRL_THREE_OFS)) begin
        rdata_nxt[STC_LSB +: 5]     = stc_r;
        rdata_nxt[TAD_DIV_LSB +: 8] = div_r;
      end else if (hit(addr, IRQ_FLAG_OFS)) begin
        rdata_nxt[IRQ_POS] = irq_r;
      end else if (addr[7:6] == BUF_BASE_OFS[7:6]) begin
        rdata_nxt[RES_W-1:0] = buf_r[addr[5:2]];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r        <= ascs_ctl_t'(CTRL_RST[7:0]);
      offset_cal_r <= 1'b0;
      spi_r        <= 4'h0;
      stc_r        <= 5'h00;
      div_r        <= DIV_RST;
      irq_r        <= 1'b0;
      state_r      <= ST_IDLE;
      tad_cnt_r    <= 9'h000;
      sample_bit_cnt_r   <= 5'h00;
      conv_cnt_r   <= 4'h0;
      seq_cnt_r    <= 4'h0;
      ptr_r        <= 4'h0;
      rdata_r      <= 32'h0000_0000;
      sh_gnd_r     <= 1'b0;
      sampling_r   <= 1'b0;
      converting_r <= 1'b0;
      sync_r       <= 3'h0;
      trig_lvl_r   <= 1'b0;
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_r[i] <= '0;
      end
    end else if (ce) begin
      ctl_r        <= ctl_nxt;
      offset_cal_r <= offset_cal_nxt;
      spi_r        <= spi_nxt;
      stc_r        <= stc_nxt;
      div_r        <= div_nxt;
      irq_r        <= irq_nxt;
      state_r      <= state_nxt;
      tad_cnt_r    <= tad_cnt_nxt;
      sample_bit_cnt_r   <= sample_bit_cnt_nxt;
      conv_cnt_r   <= conv_cnt_nxt;
      seq_cnt_r    <= seq_cnt_nxt;
      ptr_r        <= ptr_nxt;
      rdata_r      <= rdata_nxt;
      sh_gnd_r     <= offset_cal_nxt;
      sampling_r   <= (state_nxt == ST_SAMPLE);
      converting_r <= (state_nxt == ST_CONVERT);
      sync_r       <= {sync_r[1:0], ext_trigger};
      trig_lvl_r   <= trig_lvl_nxt;
      if (store) begin
        buf_r[ptr_r] <= core_result;
      end
    end
  end

  assign rdata        = rdata_r;
  assign sh_to_ground = sh_gnd_r;
  assign sampling     = sampling_r;
  assign converting   = converting_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n || !ce);

  property p_cal_ground;
    offset_cal_r |-> sh_to_ground;
  endproperty
  a_cal_ground: assert property (p_cal_ground) else $error("ground not forced in calibration");

  property p_stop_clears_auto;
    seq_end && ctl_r.stop_after_seq && !wr_one |=> !ctl_r.auto_sample ##1 state_r == ST_IDLE;
  endproperty
  a_stop_clears_auto: assert property (p_stop_clears_auto) else $error("auto-sample not stopped");

  property p_stop_kept;
    ctl_r.stop_after_seq && !wr_one |=> ctl_r.stop_after_seq;
  endproperty
  a_stop_kept: assert property (p_stop_kept) else $error("auto-clear bit lost");

  property p_done_set;
    seq_end |=> ctl_r.done && irq_r;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done or irq not set at sequence end");

  property p_done_manual;
    ctl_r.done && !ctl_r.auto_sample && !wr_one |=> ctl_r.done;
  endproperty
  a_done_manual: assert property (p_done_manual) else $error("manual done cleared by hardware");

  property p_irq_hold;
    irq_r && !wr_irq |=> irq_r;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped");

  property p_sw_trigger;
    state_r == ST_SAMPLE && ctl_r.on && ctl_r.trig_src == TRIG_SW && !ctl_r.sample |=> converting;
  endproperty
  a_sw_trigger: assert property (p_sw_trigger) else $error("software trigger missed");

  property p_auto_restart;
    store && ctl_r.auto_sample && !seq_end && !wr_one |=> ##1 sampling && ctl_r.sample && !ctl_r.done;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto acquisition not restarted");

  property p_conv_len;
    store |-> conv_cnt_r == CONV_TADS - 4'h1 && tad_tick && converting;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_abort;
    !ctl_r.on |-> !store;
  endproperty
  a_abort: assert property (p_abort) else $error("store while disabled");

  property p_ptr_wrap;
    seq_end |=> ptr_r == 4'h0 && seq_cnt_r == 4'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("buffer pointer not restarted");

  c_seq_end:  cover property (seq_end);
  c_auto_stop: cover property (seq_end && ctl_r.stop_after_seq);
  c_clocked:  cover property (sampling && ctl_r.trig_src == TRIG_CLKD ##1 converting);
  c_abort:    cover property (converting && !ctl_r.on);
endmodule

//--- verification/tb_adc_sample_convert_sequencer.sv
`timescale 1ns/1ns
module tb_adc_sample_convert_sequencer;
  import ascs_pkg::*;
  logic              core_clk;
  logic              arst_n;
  logic              ce;
  logic [7:0]        addr;
  logic [31:0]       wdata;
  logic              we;
  logic              re;
  logic [31:0]       rdata;
  logic [RES_W-1:0]  core_result;
  logic              ext_trigger;
  logic              sh_to_ground;
  logic              sampling;
  logic              converting;
  int                mismatches;
  int                comparisons;
  int                cycles;
  int                n;
  int                len;

  ascs_top u_dut (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .ce           (ce),
    .addr         (addr),
    .wdata        (wdata),
    .we           (we),
    .re           (re),
    .rdata        (rdata),
    .core_result  (core_result),
    .ext_trigger  (ext_trigger),
    .sh_to_ground (sh_to_ground),
    .sampling     (sampling),
    .converting   (converting)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ************************************************************
  // hang guard: whole run needs a few hundred cycles
  // ************************************************************
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    we    <= 1'b0;
    // let the edge that takes the write settle before anyone looks at outputs
    #1;
  endtask

  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    re   <= 1'b0;
    #1;
    chk32(name, exp, rdata);
  endtask

  // which: 0 sampling, 1 converting; cnt returns cycles waited
  task automatic wait_for(input int which, input logic lvl, output int cnt);
    cnt = 0;
    while (((which == 0) ? sampling : converting) !== lvl && cnt < 300) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (cnt >= 300) begin
      mismatches++;
      $display("ERROR wait_for %0d expected %0d seen timeout", which, lvl);
    end
  endtask

  // software-timed acquisition, then conversion length in core clocks (tad = 2 clocks)
  task automatic manual_conv();
    wr(CTRL_ONE_OFS, 32'h0000_8002);
    wait_for(0, 1'b1, n);
    repeat (4) @(posedge core_clk);
    wr(CTRL_ONE_OFS, 32'h0000_8000);
    wait_for(1, 1'b1, n);
    chk_rng("start_after_sample_clear", 0, 3, n);
    wait_for(1, 1'b0, len);
    chk_rng("conversion_cycles", 23, 25, len);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk32("outputs_after_reset", 32'h0, {29'h0, sh_to_ground, sampling, converting});
    rd_chk("ctrl_one", CTRL_ONE_OFS, 32'h0);
    rd_chk("ctrl_two", CTRL_TWO_OFS, 32'h0);
    rd_chk("ctrl_three", CTRL_THREE_OFS, 32'h0);
    rd_chk("irq_flag", IRQ_FLAG_OFS, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd_chk("unmapped", 8'h20, 32'h0);
  endtask

  task automatic t_manual();
    core_result <= 10'h2c3;
    manual_conv();
    repeat (20) @(posedge core_clk);
    rd_chk("done_sticky", CTRL_ONE_OFS, 32'h0000_8001);
    rd_chk("irq_latched", IRQ_FLAG_OFS, 32'h0000_0002);
    rd_chk("word0", BUF_BASE_OFS, 32'h0000_02c3);
    wr(CTRL_ONE_OFS, 32'h0000_8000);
    rd_chk("done_cleared", CTRL_ONE_OFS, 32'h0000_8000);
    wr(IRQ_FLAG_OFS, 32'h0);
    rd_chk("irq_cleared", IRQ_FLAG_OFS, 32'h0);
  endtask

  task automatic t_offset_cal();
    wr(CTRL_TWO_OFS, 32'h0000_1000);
    chk32("sh_to_ground_on", 32'h1, {31'h0, sh_to_ground});
    core_result <= 10'h01f;
    manual_conv();
    chk32("sh_held", 32'h1, {31'h0, sh_to_ground});
    rd_chk("cal_word0", BUF_BASE_OFS, 32'h0000_001f);
    wr(CTRL_TWO_OFS, 32'h0);
    chk32("sh_to_ground_off", 32'h0, {31'h0, sh_to_ground});
  endtask

  task automatic t_abort();
    core_result <= 10'h3ff;
    wr(CTRL_ONE_OFS, 32'h0000_8002);
    wait_for(0, 1'b1, n);
    wr(CTRL_ONE_OFS, 32'h0000_8000);
    wait_for(1, 1'b1, n);
    repeat (6) @(posedge core_clk);
    wr(CTRL_ONE_OFS, 32'h0);
    wait_for(1, 1'b0, n);
    chk_rng("abort_latency", 0, 2, n);
    repeat (30) @(posedge core_clk);
    rd_chk("word0_kept", BUF_BASE_OFS, 32'h0000_001f);
    rd_chk("no_done", CTRL_ONE_OFS, 32'h0);
  endtask

  task automatic t_clocked_auto_stop();
    wr(IRQ_FLAG_OFS, 32'h0);
    wr(CTRL_THREE_OFS, 32'h0000_0003);
    wr(CTRL_TWO_OFS, 32'h0000_0004);
    core_result <= 10'h155;
    wr(CTRL_ONE_OFS, 32'h0000_80f4);
    wait_for(0, 1'b1, n);
    chk_rng("auto_start", 0, 2, n);
    wait_for(0, 1'b0, len);
    chk_rng("sample_time_cycles", 5, 7, len);
    chk32("clocked_convert", 32'h1, {31'h0, converting});
    wait_for(1, 1'b0, len);
    chk_rng("conv1_cycles", 23, 25, len);
    core_result <= 10'h2aa;
    wait_for(0, 1'b1, n);
    chk_rng("reacquire", 0, 2, n);
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    repeat (40) @(posedge core_clk);
    #1;
    chk32("stopped", 32'h0, {30'h0, sampling, converting});
    rd_chk("auto_cleared", CTRL_ONE_OFS, 32'h0000_80f1);
    rd_chk("irq_after_seq", IRQ_FLAG_OFS, 32'h0000_0002);
    rd_chk("seq_word0", BUF_BASE_OFS, 32'h0000_0155);
    rd_chk("seq_word1", BUF_BASE_OFS + 8'h04, 32'h0000_02aa);
  endtask

  task automatic t_ext_auto();
    wr(IRQ_FLAG_OFS, 32'h0);
    wr(CTRL_TWO_OFS, 32'h0);
    wr(CTRL_ONE_OFS, 32'h0000_8044);
    wait_for(0, 1'b1, n);
    repeat (10) @(posedge core_clk);
    #1;
    chk32("waits_for_trigger", 32'h2, {30'h0, sampling, converting});
    rd_chk("sample_bit_set", CTRL_ONE_OFS, 32'h0000_8046);
    @(posedge core_clk);
    ext_trigger <= 1'b1;
    repeat (3) @(posedge core_clk);
    ext_trigger <= 1'b0;
    wait_for(1, 1'b1, n);
    chk_rng("ext_start", 0, 6, n);
    wait_for(1, 1'b0, n);
    wait_for(0, 1'b1, n);
    chk_rng("auto_resample", 0, 2, n);
    rd_chk("done_cleared_on_acq", CTRL_ONE_OFS, 32'h0000_8046);
    rd_chk("irq_still_set", IRQ_FLAG_OFS, 32'h0000_0002);
    wr(CTRL_ONE_OFS, 32'h0);
  endtask

  // clock enable low must freeze every register, so a write then is lost
  task automatic t_ce_freeze();
    @(posedge core_clk);
    ce <= 1'b0;
    wr(CTRL_THREE_OFS, 32'h0000_0007);
    @(posedge core_clk);
    ce <= 1'b1;
    rd_chk("write_ignored_ce_low", CTRL_THREE_OFS, 32'h0000_0003);
  endtask

  initial begin
    cycles      = 0;
    mismatches  = 0;
    comparisons = 0;
    arst_n      = 1'b0;
    ce          = 1'b1;
    addr        = 8'h00;
    wdata       = 32'h0;
    we          = 1'b0;
    re          = 1'b0;
    core_result = 10'h000;
    ext_trigger = 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_manual();
    t_offset_cal();
    t_abort();
    t_clocked_auto_stop();
    t_ext_auto();
    t_ce_freeze();
    end_of_test();
  end
endmodule
